//--- quad_pos_out.v
// Purpose: Quadrature A/B/Z output of an absolute position transducer
// Assumes: Position samples arrive from same-clock logic; pins are async
// Notes:   Differential pairs are formed outside as true and complement
`timescale 1ns/1ps
`include "quad_pos_map.vh"

// Function
// (R1) A and B channels report position at 0.001 inch, 1000 counts per inch.
// (R2) The index channel asserts at a position that software sets.
// (R3) A burst input replays the whole position relative to zero as pulses.
// (R4) A zero pulse captures the present position as reference, later motion counts up or down.
// (R5) In volatile mode the reference holds until a new zero or power loss, rewritable without limit.
// (R6) In non-volatile mode the reference survives power loss and allows at most 100000 writes; the write count here clears on reset, allowing 100000 more.
// (R7) Pulses go out in packets at a fixed rate independent of magnet speed.
// (R8) The cycle frequency is one of nine settings from 10 kHz to 1000 kHz.
// (R9) The integrator picks a rate no higher than the counter input limit, lower when between.
// (R10) Green shows while the magnet is in range, red on null zone, dead zone or loss.
// (R11) A and B are in quadrature, A leads increasing and B leads decreasing.
module quad_pos_out (
   input  wire                    clock,       // System clock
   input  wire                    rst,         // Sync reset, active high
   input  wire [`POS_WIDTH-1:0]   mag_pos,     // Absolute position in counts
   input  wire                    mag_valid,   // Magnet seen in programmed range
   input  wire                    mag_zone_bad,// Magnet in null or dead zone
   input  wire                    burst_pin,   // Burst input pin
   input  wire                    zero_pin,    // Zero input pin
   input  wire [`POS_WIDTH-1:0]   nv_zero,     // Stored reference from storage
   input  wire                    nv_valid,    // Stored reference present
   output reg                     nv_write,    // Write reference to storage
   output reg  [`POS_WIDTH-1:0]   nv_data,     // Reference to store
   output reg                     chan_a,      // Quadrature channel A
   output reg                     chan_b,      // Quadrature channel B
   output reg                     chan_z,      // Index channel
   output wire                    led_green,   // Healthy status LED
   output wire                    led_red,     // Fault status LED
   output wire                    irq,         // Level interrupt
   input  wire [31:0]             wb_adr_i,    // Wishbone address
   input  wire [31:0]             wb_dat_i,    // Wishbone write data
   output reg  [31:0]             wb_dat_o,    // Wishbone read data
   input  wire                    wb_we_i,     // Wishbone write enable
   input  wire [3:0]              wb_sel_i,    // Wishbone byte selects
   input  wire                    wb_stb_i,    // Wishbone strobe
   input  wire                    wb_cyc_i,    // Wishbone cycle
   output reg                     wb_ack_o     // Wishbone acknowledge
);

   localparam PW = `POS_WIDTH;

   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   reg  [31:0]   ctrl_q;
   reg  [PW-1:0] index_q;
   reg  [PW-1:0] zero_q;
   reg  [PW-1:0] out_q;         // Position already sent to counter
   reg  [16:0]   nv_cnt_q;
   reg  [`IRQ_WIDTH-1:0] istat_q;
   reg  [`IRQ_WIDTH-1:0] imask_q;
   reg  [1:0]    burst_s_q;
   reg  [1:0]    zero_s_q;
   reg           burst_d_q;
   reg           zero_d_q;
   reg  [1:0]    phase_q;
   reg  [1:0]    mode_q;
   reg           fault_d_q;
   reg           nv_loaded_q;

   localparam [1:0] ST_TRACK = 2'b00;
   localparam [1:0] ST_CLEAR = 2'b01;
   localparam [1:0] ST_BURST = 2'b10;

   wire          step_en;
   wire          acc;
   wire          wr;
   wire          rd;
   wire          burst_evt;
   wire          zero_evt;
   wire          nonvol;
   wire          nv_full;
   wire [PW-1:0] rel_pos;
   wire [PW-1:0] target;
   wire          want_up;
   wire          want_dn;
   wire          fault;
   reg  [`IRQ_WIDTH-1:0] ev;

   // Fixed-rate step enable, speed independent
   quad_rate_gen u_rate (
      .clock    (clock),
      .rst      (rst),
      .freq_sel (ctrl_q[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB]),  // [R8]
      .step_en  (step_en)                                 // [R7]
   );

   // ------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         burst_s_q <= 2'b00;
         zero_s_q  <= 2'b00;
         burst_d_q <= 1'b0;
         zero_d_q  <= 1'b0;
      end else begin
         burst_s_q <= {burst_s_q[0], burst_pin};
         zero_s_q  <= {zero_s_q[0], zero_pin};
         burst_d_q <= burst_s_q[1];
         zero_d_q  <= zero_s_q[1];
      end
   end

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr       = acc & wb_we_i;
   assign rd       = acc & ~wb_we_i;
   assign nonvol   = ctrl_q[`CTRL_NONVOL_BIT];
   assign nv_full  = (nv_cnt_q >= 17'd`NV_WRITE_LIMIT);
   assign fault    = ~mag_valid | mag_zone_bad;

   // Rising pin edge or software strobe bit
   assign burst_evt = (burst_s_q[1] & ~burst_d_q) |
                      (wr & (wb_adr_i[7:0] == `REG_CTRL) & wb_sel_i[0] & wb_dat_i[`CTRL_BURST_BIT]);
   assign zero_evt  = (zero_s_q[1] & ~zero_d_q) |
                      (wr & (wb_adr_i[7:0] == `REG_CTRL) & wb_sel_i[0] & wb_dat_i[`CTRL_ZERO_BIT]);

   // Position relative to reference, in 0.001 inch counts
   assign rel_pos = mag_pos - zero_q;                   // [R1] [R4]
   assign target  = (mode_q == ST_CLEAR) ? {PW{1'b0}} : rel_pos;
   assign want_up = (out_q != target) & ~target[PW-1] & (out_q[PW-1] | (out_q < target));
   assign want_dn = (out_q != target) & ~want_up;

   // ------------------------------------------------------------
   // Reference capture and storage
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         zero_q      <= {PW{1'b0}};
         nv_cnt_q    <= 17'h00000;
         nv_write    <= 1'b0;
         nv_data     <= {PW{1'b0}};
         nv_loaded_q <= 1'b0;
      end else begin
         nv_write <= 1'b0;
         if (!nv_loaded_q) begin
            nv_loaded_q <= 1'b1;
            // Mode bit is cleared by reset, so trust the stored flag
            if (nv_valid)
               zero_q <= nv_zero;                       // [R6]
         end else if (zero_evt & mag_valid) begin
            if (!nonvol) begin
               zero_q <= mag_pos;                       // [R4] [R5]
            end else if (!nv_full) begin
               zero_q   <= mag_pos;                     // [R4]
               nv_write <= 1'b1;                        // [R6]
               nv_data  <= mag_pos;
               nv_cnt_q <= nv_cnt_q + 17'h00001;        // [R6]
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Output sequencer: track, clear then burst replay
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         mode_q <= ST_TRACK;
      end else begin
         case (mode_q)
            ST_TRACK: if (burst_evt | zero_evt) mode_q <= ST_CLEAR;
            ST_CLEAR: if (out_q == {PW{1'b0}}) mode_q <= ST_BURST;   // [R3]
            ST_BURST: if (out_q == rel_pos) mode_q <= ST_TRACK;      // [R3]
            default:  mode_q <= ST_TRACK;
         endcase
      end
   end

   // Quadrature stepping at fixed rate toward target
   always @(posedge clock) begin
      if (rst) begin
         out_q   <= {PW{1'b0}};
         phase_q <= 2'b00;
      end else if (step_en & ~fault & (want_up | want_dn)) begin   // [R7]
         if (want_up) begin
            out_q   <= out_q + {{(PW-1){1'b0}}, 1'b1};
            phase_q <= phase_q + 2'b01;                // [R11]
         end else begin
            out_q   <= out_q - {{(PW-1){1'b0}}, 1'b1};
            phase_q <= phase_q - 2'b01;                // [R11]
         end
      end
   end

   // Gray sequence 00,10,11,01: A leads counting up
   always @(posedge clock) begin
      if (rst) begin
         chan_a <= 1'b0;
         chan_b <= 1'b0;
         chan_z <= 1'b0;
      end else begin
         chan_a <= (phase_q == 2'b01) | (phase_q == 2'b10);   // [R11]
         chan_b <= phase_q[1];                                 // [R11]
         chan_z <= (out_q == index_q);                         // [R2]
      end
   end

   // ------------------------------------------------------------
   // Interrupt status, set wins over read clear
   // ------------------------------------------------------------
   always @* begin
      ev = {`IRQ_WIDTH{1'b0}};
      ev[`IRQ_BURST_DONE] = (mode_q == ST_BURST) & (out_q == rel_pos);
      ev[`IRQ_ZERO_SET]   = nv_write | (zero_evt & mag_valid & ~nonvol);
      ev[`IRQ_FAULT]      = fault & ~fault_d_q;
      ev[`IRQ_NV_LIMIT]   = zero_evt & nonvol & nv_full;
   end

   always @(posedge clock) begin
      if (rst) begin
         istat_q   <= {`IRQ_WIDTH{1'b0}};
         fault_d_q <= 1'b0;
      end else begin
         fault_d_q <= fault;
         if (rd & (wb_adr_i[7:0] == `REG_IRQ_STAT))
            istat_q <= ev;
         else
            istat_q <= istat_q | ev;
      end
   end

   assign irq       = |(istat_q & imask_q);
   assign led_green = ~fault;                          // [R10]
   assign led_red   = fault;                           // [R10]

   // ------------------------------------------------------------
   // Register writes and read mux
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         ctrl_q   <= `CTRL_RESET_VAL;
         index_q  <= {PW{1'b0}};
         imask_q  <= {`IRQ_WIDTH{1'b0}};
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         if (wr & wb_sel_i[0]) begin
            case (wb_adr_i[7:0])
               `REG_CTRL:      ctrl_q[4:0] <= wb_dat_i[4:0];   // [R8]
               `REG_INDEX_POS: index_q     <= wb_dat_i[PW-1:0]; // [R2]
               `REG_IRQ_MASK:  imask_q     <= wb_dat_i[`IRQ_WIDTH-1:0];
               default: ;
            endcase
         end
         if (rd) begin
            case (wb_adr_i[7:0])
               `REG_CTRL:      wb_dat_o <= {27'h0, ctrl_q[4:0]};
               `REG_STATUS:    wb_dat_o <= {26'h0, mode_q, nv_full, fault, mag_zone_bad, mag_valid};
               `REG_IRQ_STAT:  wb_dat_o <= {28'h0, istat_q};
               `REG_IRQ_MASK:  wb_dat_o <= {28'h0, imask_q};
               `REG_INDEX_POS: wb_dat_o <= {8'h0, index_q};
               `REG_ZERO_POS:  wb_dat_o <= {8'h0, zero_q};
               `REG_REL_POS:   wb_dat_o <= {8'h0, out_q};
               `REG_NV_COUNT:  wb_dat_o <= {15'h0, nv_cnt_q};
               default:        wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

//--- quad_pos_map.vh
// Purpose: Constants for the quadrature position burst output block
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef QUAD_POS_MAP_VH
`define QUAD_POS_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0c
`define REG_INDEX_POS   8'h10
`define REG_ZERO_POS    8'h14
`define REG_REL_POS     8'h18
`define REG_NV_COUNT    8'h1c

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define CTRL_FREQ_LSB   0
`define CTRL_FREQ_MSB   3
`define CTRL_NONVOL_BIT 4
`define CTRL_BURST_BIT  5
`define CTRL_ZERO_BIT   6
`define CTRL_RESET_VAL  32'h0000_0000

// ---------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------
`define IRQ_BURST_DONE  0
`define IRQ_ZERO_SET    1
`define IRQ_FAULT       2
`define IRQ_NV_LIMIT    3
`define IRQ_WIDTH       4

// ---------------------------------------------------------------
// Timing and sizes
// ---------------------------------------------------------------
`define CLK_HZ          125000000
`define COUNTS_PER_INCH 1000
`define NV_WRITE_LIMIT  100000
`define POS_WIDTH       24
`define FREQ_SEL_W      4

`endif

//--- quad_rate_gen.v
// Purpose: Step-rate divider for the quadrature output
// Assumes: 125 MHz clock, selection of nine cycle frequencies
// Notes:   Emits four enable pulses per quadrature cycle
`timescale 1ns/1ps
`include "quad_pos_map.vh"

module quad_rate_gen (
   input  wire                     clock,    // System clock
   input  wire                     rst,      // Sync reset, active high
   input  wire [`FREQ_SEL_W-1:0]   freq_sel, // Cycle frequency choice
   output reg                      step_en   // One-cycle step enable
);

   // ------------------------------------------------------------
   // Divider table
   // ------------------------------------------------------------
   localparam [31:0] F0 = 32'd10000;
   localparam [31:0] F1 = 32'd25000;
   localparam [31:0] F2 = 32'd50000;
   localparam [31:0] F3 = 32'd75000;
   localparam [31:0] F4 = 32'd100000;
   localparam [31:0] F5 = 32'd150000;
   localparam [31:0] F6 = 32'd250000;
   localparam [31:0] F7 = 32'd500000;
   localparam [31:0] F8 = 32'd1000000;

   reg  [31:0] freq_hz;
   wire [31:0] div_w;
   reg  [15:0] cnt_q;

   // Selected quadrature cycle frequency, unused codes take slowest
   always @* begin
      case (freq_sel)
         4'h0:    freq_hz = F0;
         4'h1:    freq_hz = F1;
         4'h2:    freq_hz = F2;
         4'h3:    freq_hz = F3;
         4'h4:    freq_hz = F4;
         4'h5:    freq_hz = F5;
         4'h6:    freq_hz = F6;
         4'h7:    freq_hz = F7;
         4'h8:    freq_hz = F8;
         default: freq_hz = F0;
      endcase
   end

   // Four edges per cycle; round down keeps rate at or above setting
   assign div_w = `CLK_HZ / (freq_hz * 32'd4);

   // Step pulse counter
   always @(posedge clock) begin
      if (rst) begin
         cnt_q   <= 16'h0000;
         step_en <= 1'b0;
      end else if (cnt_q >= div_w[15:0] - 16'h0001) begin
         cnt_q   <= 16'h0000;
         step_en <= 1'b1;
      end else begin
         cnt_q   <= cnt_q + 16'h0001;
         step_en <= 1'b0;
      end
   end

endmodule

//--- quad_pos_out_monitor.sv
// Purpose: Bus and output checks for quad_pos_out
// Assumes: One clock, sync active-high reset
// Notes:   Bound to every quad_pos_out instance
`timescale 1ns/1ps
module quad_pos_out_monitor (
   input wire        clock,        // System clock
   input wire        rst,          // Sync reset
   input wire        mag_valid,    // Magnet in range
   input wire        mag_zone_bad, // Magnet in bad zone
   input wire        nv_write,     // Storage write
   input wire        chan_a,       // Channel A
   input wire        chan_b,       // Channel B
   input wire        led_green,    // Healthy LED
   input wire        led_red,      // Fault LED
   input wire        irq,          // Interrupt
   input wire [31:0] wb_adr_i,     // Bus address
   input wire [31:0] wb_dat_o,     // Bus read data
   input wire        wb_we_i,      // Bus write enable
   input wire        wb_stb_i,     // Bus strobe
   input wire        wb_cyc_i,     // Bus cycle
   input wire        wb_ack_o      // Bus acknowledge
);
   // ----------------------------------------
   // Step spacing helper
   // ----------------------------------------
   reg  [1:0]  ab_q;
   reg  [11:0] gap_q;
   wire        step_w = ({chan_a, chan_b} != ab_q);
   // Cycles since the last quadrature edge
   always @(posedge clock) begin
      ab_q <= {chan_a, chan_b};
      if (rst)
         gap_q <= 12'hfff;
      else if (step_w)
         gap_q <= 12'h000;
      else if (gap_q != 12'hfff)
         gap_q <= gap_q + 12'h001;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_timing: assert property (s_take |=> s_answer)
      else $error("ack not one cycle after request");
   a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:0] > 8'h1c |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_quad_gray: assert property ($changed(chan_a) |-> $stable(chan_b))
      else $error("both channels moved together");
   a_step_spacing: assert property (step_w |-> gap_q >= 12'd30)
      else $error("steps closer than fastest rate");
   a_led_fault: assert property (led_red == (!mag_valid || mag_zone_bad))
      else $error("fault led wrong");
   a_led_green: assert property (led_green == !led_red)
      else $error("green led wrong");
   a_fault_pause: assert property (led_red [*8] |-> !step_w)
      else $error("stepping during fault");
   a_reset_quiet: assert property ($fell(rst) |-> !irq && !chan_a && !chan_b && !wb_ack_o)
      else $error("outputs active after reset");
   a_nv_pulse: assert property (nv_write |=> !nv_write)
      else $error("storage write longer than one cycle");
endmodule

bind quad_pos_out quad_pos_out_monitor u_mon (.clock, .rst, .mag_valid, .mag_zone_bad,
   .nv_write, .chan_a, .chan_b, .led_green, .led_red, .irq, .wb_adr_i, .wb_dat_o,
   .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o);

//--- quad_counter_card.sv
// Purpose: Incremental counter card that decodes A/B/Z
// Assumes: Card samples on the system clock
// Notes:   Phase 00,10,11,01 as (A,B) counts up
`timescale 1ns/1ps
module quad_counter_card (
   input  wire clock,     // Sampling clock
   input  wire chan_a,    // Channel A
   input  wire chan_b,    // Channel B
   input  wire chan_z,    // Index channel
   input  wire clr_min,   // Restart minimum tracking
   output int  count,     // Position count
   output int  cnt_min,   // Lowest count seen
   output int  z_count,   // Count at index rise
   output int  bad_steps  // Illegal phase jumps
);
   reg  [1:0] ph_q = 2'h0;
   reg  [1:0] z_q = 2'h0;
   wire [1:0] ph_w = {chan_b, chan_a ^ chan_b};
   // Decode phase moves; the card keeps up at 1000 kHz
   always @(posedge clock) begin
      ph_q <= ph_w;
      z_q <= {z_q[0], chan_z};
      case (ph_w - ph_q)
         2'd1: count <= count + 1;
         2'd3: count <= count - 1;
         2'd2: bad_steps <= bad_steps + 1;
         default: ;
      endcase
      if (clr_min)
         cnt_min <= count;
      else if (count < cnt_min)
         cnt_min <= count;
      if (z_q == 2'b01)
         z_count <= count;
   end
endmodule

//--- tb.sv
// Purpose: Self-checking bench for quad_pos_out
// Assumes: 125 MHz clock, classic Wishbone access
// Notes:   Counter card model watches the outputs
`timescale 1ns/1ps
`include "quad_pos_map.vh"
module tb;
   reg         clock = 1'b0, rst = 1'b1, mag_valid = 1'b0, mag_zone_bad = 1'b0;
   reg         burst_pin = 1'b0, zero_pin = 1'b0, nv_valid = 1'b0, clr_min = 1'b0;
   reg         wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
   reg  [23:0] mag_pos = 24'h0, nv_zero = 24'h0, nv_last = 24'h0;
   reg  [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [1:0]  ab_q = 2'h0;
   wire [31:0] wb_dat_o;
   wire [23:0] nv_data;
   wire        nv_write, chan_a, chan_b, chan_z, led_green, led_red, irq, wb_ack_o;
   wire        stepped = ({chan_a, chan_b} != ab_q);
   int         card_count, card_min, z_count, bad_steps, nv_seen, n, i;
   int         miscompares = 0, total_checks = 0;
   int         khz [9] = '{10, 25, 50, 75, 100, 150, 250, 500, 1000};

   quad_pos_out DUT (.clock, .rst, .mag_pos, .mag_valid, .mag_zone_bad, .burst_pin, .zero_pin,
      .nv_zero, .nv_valid, .nv_write, .nv_data, .chan_a, .chan_b, .chan_z, .led_green,
      .led_red, .irq, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i,
      .wb_cyc_i, .wb_ack_o);
   quad_counter_card card (.clock, .chan_a, .chan_b, .chan_z, .clr_min, .count(card_count),
      .cnt_min(card_min), .z_count, .bad_steps);

   // Clock, step tracking and storage write capture
   always #4 clock = ~clock;
   always @(posedge clock) begin
      ab_q <= {chan_a, chan_b};
      if (nv_write) begin
         nv_seen <= nv_seen + 1;
         nv_last <= nv_data;
      end
   end

   task check(input [31:0] got, input [31:0] exp);
      begin
         total_checks++;
         if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   // One classic Wishbone cycle, then one idle cycle
   task bus(input [7:0] a, input w, input [31:0] d, output [31:0] q);
      int k;
      begin
         k = 0;
         wb_adr_i <= {24'h0, a};
         wb_we_i <= w;
         wb_dat_i <= d;
         wb_sel_i <= 4'hf;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         do begin
            @(posedge clock);
            k++;
         end while (wb_ack_o !== 1'b1 && k < 50);
         q = wb_dat_o;
         if (k >= 50) miscompares++;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge clock);
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      reg [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task rd(input [7:0] a, input [31:0] m, input [31:0] exp);
      reg [31:0] q;
      begin
         bus(a, 1'b0, 32'h0, q);
         check(q & m, exp);
      end
   endtask

   task wait_step(output int c);
      begin
         c = 0;
         do begin
            @(posedge clock);
            c++;
         end while (!stepped && c < 8000);
      end
   endtask

   // Wait until no step for 100 cycles
   task settle;
      int q, k;
      begin
         q = 0;
         for (k = 0; k < 40000 && q < 100; k++) begin
            @(posedge clock);
            q = stepped ? 0 : q + 1;
         end
      end
   endtask

   task pin(input z);
      begin
         if (z) zero_pin <= 1'b1;
         else burst_pin <= 1'b1;
         repeat (4) @(posedge clock);
         zero_pin <= 1'b0;
         burst_pin <= 1'b0;
         @(posedge clock);
      end
   endtask

   task results;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   // Watchdog
   initial begin
      repeat (90000) @(posedge clock);
      miscompares++;
      results;
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      mag_valid <= 1'b1;
      @(posedge clock);
      rd(`REG_CTRL, 32'hffffffff, `CTRL_RESET_VAL);
      rd(8'h20, 32'hffffffff, 32'h0);
      wr(`REG_INDEX_POS, 32'd5);
      rd(`REG_INDEX_POS, 32'hffffff, 32'd5);
      for (i = 0; i < 9; i++) begin
         wr(`REG_CTRL, i);
         mag_pos <= mag_pos + 24'd2;
         wait_step(n);
         wait_step(n);
         check(n, 125000000 / (4000 * khz[i]));
      end
      settle;
      check(card_count, 18);
      check(z_count, 5);
      rd(`REG_REL_POS, 32'hffffff, 32'd18);
      wr(`REG_IRQ_MASK, 32'h2);
      pin(1'b1);
      settle;
      check(card_count, 0);
      check(irq, 1'b1);
      rd(`REG_IRQ_STAT, 32'h2, 32'h2);
      check(irq, 1'b0);
      rd(`REG_ZERO_POS, 32'hffffff, 32'd18);
      check(nv_seen, 0);
      mag_pos <= 24'd21;
      settle;
      check(card_count, 3);
      mag_pos <= 24'd19;
      settle;
      check(card_count, 1);
      wr(`REG_IRQ_MASK, 32'h1);
      clr_min <= 1'b1;
      @(posedge clock);
      clr_min <= 1'b0;
      pin(1'b0);
      settle;
      check(card_min, 0);
      check(card_count, 1);
      check(irq, 1'b1);
      rd(`REG_IRQ_STAT, 32'h1, 32'h1);
      wr(`REG_CTRL, 32'h18);
      mag_pos <= 24'd30;
      settle;
      pin(1'b1);
      settle;
      check(card_count, 0);
      check(nv_seen, 1);
      check(nv_last, 30);
      rd(`REG_NV_COUNT, 32'hffffffff, 32'd1);
      check(irq, 1'b1);
      mag_zone_bad <= 1'b1;
      mag_pos <= 24'd40;
      repeat (200) @(posedge clock);
      check({led_red, led_green, card_count[0]}, 3'b100);
      mag_zone_bad <= 1'b0;
      mag_valid <= 1'b0;
      @(posedge clock);
      check({led_red, led_green}, 2'b10);
      mag_valid <= 1'b1;
      settle;
      check(card_count, 10);
      check(bad_steps, 0);
      rst <= 1'b1;
      nv_valid <= 1'b1;
      nv_zero <= 24'd30;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(`REG_ZERO_POS, 32'hffffff, 32'd30);
      results;
   end
endmodule
